/* File: drive_fc_cfg.svh */
// Offsets, codes, field positions and reset values of the feature-control block.
`ifndef DRIVE_FC_CFG_SVH
`define DRIVE_FC_CFG_SVH
`define OFS_FUNC      8'h00
`define OFS_FEAT      8'h04
`define OFS_STATE     8'h08
`define OFS_OPT       8'h0c
`define OFS_CTRL      8'h10
`define OFS_SETF      8'h14
`define OFS_STAT      8'h18
`define OFS_RES       8'h1c
`define OFS_IDW85     8'h20
`define OFS_INTV      8'h24
`define OFS_SPER      8'h28
`define OFS_LIM       8'h2c
`define OFS_QIDX      8'h30
`define OFS_QADR      8'h34
`define OFS_QDAT      8'h38
`define FN_SET        16'h0001
`define FN_GET        16'h0002
`define FN_OPT        16'h0003
`define FC_WCACHE     16'h0001
`define FC_REORD      16'h0002
`define FC_TLOG       16'h0003
`define WC_HOST       2'h1
`define WC_ON         2'h2
`define WC_OFF        2'h3
`define RO_EN         16'h0001
`define RO_DIS        16'h0002
`define INTV_BAD      16'h0000
`define INTV_DFLT     16'h0001
`define SPER_DFLT     16'h0001
`define LIM_DFLT      32'h0000_0000
`define SETF_DFLT     1'b1
`define QMARK         8'h80
`define QLAST         7'h7f
`define IDW85_WCE_BIT 5
`define OPT_PERS_BIT  0
`define CTRL_GO_BIT   0
`define STAT_BUSY_BIT 0
`define STAT_DONE_BIT 1
`define STAT_ABRT_BIT 2
`endif

/* File: drive_fc_pkg.sv */
// Types shared by the feature-control block.
`default_nettype none
package drive_fc_pkg;
  `include "drive_fc_cfg.svh"

  typedef enum logic {ST_IDLE, ST_FILL} phase_e;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdat;
    logic [15:0] func;
    logic [15:0] feat;
    logic [15:0] stv;
    logic [15:0] opt;
    logic [15:0] res;
    logic [15:0] intv;
    logic [15:0] nv_intv;
    logic [15:0] sper;
    logic [31:0] lim;
    logic [1:0]  wc_mode;
    logic [1:0]  nv_wc;
    logic [1:0]  pers;
    logic        setf;
    logic        wc_en;
    logic        reorder;
    logic        done;
    logic        abort;
    logic        busy;
    phase_e      ph;
    logic [6:0]  qidx;
    logic [6:0]  qadr;
    logic [6:0]  fcnt;
    logic [1:0]  hr_s;
    logic [7:0]  t1;
    logic [7:0]  t2;
  } state_s;
endpackage : drive_fc_pkg
`default_nettype wire

/* File: drive_fc_ctl.sv */
// Feature-control command interpreter with Wishbone register access.
//
// Local design decisions: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Host-controlled cache state follows Set Features.
// - States 2 and 3 force cache on/off.
// - Set Features accepted but ignored while forced.
// - Identify word 85 bit 5 shows real cache.
// - Cache control defaults to host-controlled state.
// - Reordering feature, enabled by default.
// - Reorder disable completes without error, ignored.
// - Logging interval in minutes, zero rejected.
// - Interval change clears queue, index zero.
// - First entry current temperature, rest 80h.
// - Interval change keeps period and limits.
// - Logging interval defaults to one minute.
// - Function code selects set, get, option flags.
// - Option bit 0 makes change persistent.
module drive_fc_ctl
  import drive_fc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        hard_rst_i,
  input  wire logic [7:0]  temp_i,
  input  wire logic        sample_i,
  output logic             write_cache_en_o,
  output logic             idw85_wce_o,
  output logic             reorder_en_o,
  output logic      [15:0] log_interval_o,
  output logic             queue_busy_o
);
  import drive_fc_pkg::*;

  localparam state_s RST = '{
    ack: 1'b0, rdat: 32'h0000_0000, func: 16'h0000, feat: 16'h0000,
    stv: 16'h0000, opt: 16'h0000, res: 16'h0000,
    intv: `INTV_DFLT, nv_intv: `INTV_DFLT, sper: `SPER_DFLT, lim: `LIM_DFLT,
    wc_mode: `WC_HOST, nv_wc: `WC_HOST, pers: 2'h0, setf: `SETF_DFLT,
    wc_en: `SETF_DFLT, reorder: 1'b1, done: 1'b0, abort: 1'b0, busy: 1'b0,
    ph: ST_IDLE, qidx: 7'h00, qadr: 7'h00, fcnt: 7'h00, hr_s: 2'h0,
    t1: 8'h00, t2: 8'h00};

  state_s     st;
  state_s     n;
  logic [7:0] qmem [0:127];
  logic       mem_we;
  logic [6:0] mem_wa;
  logic [7:0] mem_wd;
  logic [7:0] ra;
  logic       wr;
  logic       rd;
  logic       go;

  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  sel);
    merge16 = {sel[1] ? new_v[15:8] : old_v[15:8], sel[0] ? new_v[7:0] : old_v[7:0]};
  endfunction : merge16

  //////////////////////////////////////////////////////////////////////////////

  always_comb begin
    n      = st;
    mem_we = 1'b0;
    mem_wa = 7'h00;
    mem_wd = 8'h00;
    ra     = {wb_adr_i[7:2], 2'b00};
    n.ack  = wb_cyc_i & wb_stb_i & ~st.ack;
    wr     = n.ack & wb_we_i;
    rd     = n.ack & ~wb_we_i;
    go     = wr && (ra == `OFS_CTRL) && wb_sel_i[0] && wb_dat_i[`CTRL_GO_BIT]
             && (st.ph == ST_IDLE);
    // The hard reset and temperature pins pass two flip-flops first; sample_i is used directly.
    n.hr_s = {st.hr_s[0], hard_rst_i};
    n.t1   = temp_i;
    n.t2   = st.t1;

    if (wr) begin
      case (ra)
        `OFS_FUNC:  n.func  = merge16(st.func, wb_dat_i, wb_sel_i);
        `OFS_FEAT:  n.feat  = merge16(st.feat, wb_dat_i, wb_sel_i);
        `OFS_STATE: n.stv   = merge16(st.stv, wb_dat_i, wb_sel_i);
        `OFS_OPT:   n.opt   = merge16(st.opt, wb_dat_i, wb_sel_i);
        // The write always lands; only host-controlled mode lets it reach the cache.
        `OFS_SETF:  if (wb_sel_i[0]) n.setf = wb_dat_i[0];
        `OFS_SPER:  n.sper  = merge16(st.sper, wb_dat_i, wb_sel_i);
        `OFS_LIM: begin
          for (int b = 0; b < 4; b++) begin
            if (wb_sel_i[b]) n.lim[8*b +: 8] = wb_dat_i[8*b +: 8];
          end
        end
        `OFS_QADR:  if (wb_sel_i[0]) n.qadr = wb_dat_i[6:0];
        default: ;
      endcase
    end

    if (rd) begin
      case (ra)
        `OFS_FUNC:  n.rdat = {16'h0000, st.func};
        `OFS_FEAT:  n.rdat = {16'h0000, st.feat};
        `OFS_STATE: n.rdat = {16'h0000, st.stv};
        `OFS_OPT:   n.rdat = {16'h0000, st.opt};
        `OFS_SETF:  n.rdat = {31'h0000_0000, st.setf};
        `OFS_STAT:  n.rdat = {29'h0000_0000, st.abort, st.done, st.busy};
        `OFS_RES:   n.rdat = {16'h0000, st.res};
        `OFS_IDW85: begin
          n.rdat                 = 32'h0000_0000;
          n.rdat[`IDW85_WCE_BIT] = st.wc_en;
        end
        `OFS_INTV:  n.rdat = {16'h0000, st.intv};
        `OFS_SPER:  n.rdat = {16'h0000, st.sper};
        `OFS_LIM:   n.rdat = st.lim;
        `OFS_QIDX:  n.rdat = {25'h000_0000, st.qidx};
        `OFS_QADR:  n.rdat = {25'h000_0000, st.qadr};
        `OFS_QDAT:  n.rdat = {24'h00_0000, qmem[st.qadr]};
        default:    n.rdat = 32'h0000_0000;
      endcase
    end

    //////////////////////////////////////////////////////////////////////////////
    // Command execution completes in the cycle of the go write.

    if (go) begin
      n.done  = 1'b1;
      n.abort = 1'b0;
      n.res   = 16'h0000;
      case (st.func)
        `FN_SET: begin
          case (st.feat)
            `FC_WCACHE: begin
              if (st.stv == {14'h0000, `WC_HOST} || st.stv == {14'h0000, `WC_ON}
                  || st.stv == {14'h0000, `WC_OFF}) begin
                n.wc_mode = st.stv[1:0];
                n.pers[0] = st.opt[`OPT_PERS_BIT];
                if (st.opt[`OPT_PERS_BIT]) n.nv_wc = st.stv[1:0];
              end else begin
                n.abort = 1'b1;
              end
            end
            `FC_REORD: begin
              // Disabling completes cleanly but reordering stays on.
              if (st.stv != `RO_EN && st.stv != `RO_DIS) n.abort = 1'b1;
            end
            `FC_TLOG: begin
              if (st.stv == `INTV_BAD) begin
                n.abort = 1'b1;
              end else begin
                n.intv    = st.stv;
                n.pers[1] = st.opt[`OPT_PERS_BIT];
                if (st.opt[`OPT_PERS_BIT]) n.nv_intv = st.stv;
                n.qidx    = 7'h00;
                n.fcnt    = 7'h00;
                n.ph      = ST_FILL;
                n.busy    = 1'b1;
              end
            end
            default: n.abort = 1'b1;
          endcase
        end
        `FN_GET: begin
          case (st.feat)
            `FC_WCACHE: n.res = {14'h0000, st.wc_mode};
            `FC_REORD:  n.res = `RO_EN;
            `FC_TLOG:   n.res = st.intv;
            default:    n.abort = 1'b1;
          endcase
        end
        `FN_OPT: begin
          case (st.feat)
            `FC_WCACHE: n.res = {15'h0000, st.pers[0]};
            `FC_REORD:  n.res = 16'h0000;
            `FC_TLOG:   n.res = {15'h0000, st.pers[1]};
            default:    n.abort = 1'b1;
          endcase
        end
        default: n.abort = 1'b1;
      endcase
    end

    //////////////////////////////////////////////////////////////////////////////
    // Queue upkeep; period and limits are never touched here.

    case (st.ph)
      ST_IDLE: begin
        // A sample in the cycle of an interval go is dropped so the cleared index stands.
        if (sample_i && n.ph == ST_IDLE) begin
          n.qidx = st.qidx + 7'h01;
          mem_we = 1'b1;
          mem_wa = st.qidx + 7'h01;
          mem_wd = st.t2;
        end
      end
      ST_FILL: begin
        mem_we = 1'b1;
        mem_wa = st.fcnt;
        mem_wd = (st.fcnt == 7'h00) ? st.t2 : `QMARK;
        n.fcnt = st.fcnt + 7'h01;
        if (st.fcnt == `QLAST) begin
          n.ph   = ST_IDLE;
          n.busy = 1'b0;
        end
      end
      default: n.ph = ST_IDLE;
    endcase

    // A hard reset drops cache mode and interval back to the last persistent ones, and Set Features to its default.
    if (st.hr_s[1]) begin
      n.wc_mode = st.nv_wc;
      n.intv    = st.nv_intv;
      n.setf    = `SETF_DFLT;
    end

    n.wc_en = (n.wc_mode == `WC_HOST) ? n.setf : (n.wc_mode == `WC_ON);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= RST;
    end else begin
      st <= n;
    end
  end

  // The queue has no reset: its contents are defined only by an interval write's refill or by sample writes.
  always_ff @(posedge clk_i) begin
    if (mem_we) begin
      qmem[mem_wa] <= mem_wd;
    end
  end

  assign wb_dat_o         = st.rdat;
  assign wb_ack_o         = st.ack;
  assign write_cache_en_o = st.wc_en;
  assign idw85_wce_o      = st.wc_en;
  assign reorder_en_o     = st.reorder;
  assign log_interval_o   = st.intv;
  assign queue_busy_o     = st.busy;

  //////////////////////////////////////////////////////////////////////////////

  sequence s_go_cmd(logic [15:0] fn, logic [15:0] fc);
    go && st.func == fn && st.feat == fc;
  endsequence

  sequence s_setf_write;
    wr && ra == `OFS_SETF && wb_sel_i[0];
  endsequence

  a_wc_follow: assert property (@(posedge clk_i) disable iff (rst_i)
    st.wc_mode == `WC_HOST |-> write_cache_en_o == st.setf)
    else $error("cache does not follow set features");

  a_wc_forced: assert property (@(posedge clk_i) disable iff (rst_i)
    st.wc_mode != `WC_HOST |-> write_cache_en_o == (st.wc_mode == `WC_ON))
    else $error("forced cache state wrong");

  a_setf_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
    s_setf_write and (st.wc_mode != `WC_HOST) and !st.hr_s[1] and !go
    |=> $stable(write_cache_en_o) && st.ack)
    else $error("set features changed forced cache");

  a_idw85_true: assert property (@(posedge clk_i) disable iff (rst_i)
    idw85_wce_o == write_cache_en_o)
    else $error("identify bit differs from cache state");

  a_reset_dflt: assert property (@(posedge clk_i)
    rst_i |=> st.wc_mode == `WC_HOST && write_cache_en_o)
    else $error("cache control not default after reset");

  a_reorder_on: assert property (@(posedge clk_i) disable iff (rst_i)
    s_go_cmd(`FN_SET, `FC_REORD) and st.stv == `RO_DIS |=> !st.abort && reorder_en_o)
    else $error("reorder disable not ignored cleanly");

  a_intv_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    s_go_cmd(`FN_SET, `FC_TLOG) and st.stv == `INTV_BAD and !st.hr_s[1]
    |=> st.abort && $stable(log_interval_o))
    else $error("zero interval accepted");

  a_queue_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    s_go_cmd(`FN_SET, `FC_TLOG) and st.stv != `INTV_BAD
    |=> st.qidx == 7'h00 && queue_busy_o ##128 !queue_busy_o)
    else $error("queue clear wrong length");

  a_fill_mark: assert property (@(posedge clk_i) disable iff (rst_i)
    st.ph == ST_FILL && st.fcnt != 7'h00 |-> mem_we && mem_wd == `QMARK)
    else $error("fill marker wrong");

  a_limits_kept: assert property (@(posedge clk_i) disable iff (rst_i)
    st.ph == ST_FILL && !wr |=> $stable(st.lim) && $stable(st.sper))
    else $error("limits changed by interval write");

  a_intv_dflt: assert property (@(posedge clk_i)
    rst_i |=> log_interval_o == `INTV_DFLT)
    else $error("interval not one minute after reset");

  a_bad_feat: assert property (@(posedge clk_i) disable iff (rst_i)
    go && st.func == `FN_SET && st.feat > `FC_TLOG |=> st.abort && st.done)
    else $error("unknown feature not aborted");

  a_get_state: assert property (@(posedge clk_i) disable iff (rst_i)
    s_go_cmd(`FN_GET, `FC_WCACHE) |=> st.res == {14'h0000, $past(st.wc_mode)})
    else $error("get state result wrong");

  a_wc_off: assert property (@(posedge clk_i) disable iff (rst_i)
    s_go_cmd(`FN_SET, `FC_WCACHE) and st.stv == {14'h0000, `WC_OFF} and !st.hr_s[1]
    |=> !write_cache_en_o && !st.abort)
    else $error("forced off state not applied");

  a_reorder_dflt: assert property (@(posedge clk_i) disable iff (rst_i)
    reorder_en_o)
    else $error("reordering not enabled");

  a_intv_set: assert property (@(posedge clk_i) disable iff (rst_i)
    s_go_cmd(`FN_SET, `FC_TLOG) and st.stv != `INTV_BAD and !st.hr_s[1]
    |=> log_interval_o == $past(st.stv) && !st.abort)
    else $error("valid interval not taken");

  a_fill_idx: assert property (@(posedge clk_i) disable iff (rst_i)
    st.ph == ST_FILL |-> st.qidx == 7'h00)
    else $error("queue index moved during refill");

  a_fill_first: assert property (@(posedge clk_i) disable iff (rst_i)
    st.ph == ST_FILL && st.fcnt == 7'h00 |-> mem_we && mem_wa == 7'h00 && mem_wd == st.t2)
    else $error("first queue entry not current temperature");

  a_go_limits: assert property (@(posedge clk_i) disable iff (rst_i)
    s_go_cmd(`FN_SET, `FC_TLOG) |=> $stable(st.lim) && $stable(st.sper))
    else $error("interval command changed limits");

  a_bad_func: assert property (@(posedge clk_i) disable iff (rst_i)
    go && st.func != `FN_SET && st.func != `FN_GET && st.func != `FN_OPT
    |=> st.abort && st.done)
    else $error("unknown function not aborted");

  a_hard_revert: assert property (@(posedge clk_i) disable iff (rst_i)
    st.hr_s[1] |=> st.wc_mode == $past(st.nv_wc) && log_interval_o == $past(st.nv_intv)
      && st.setf)
    else $error("hard reset did not restore persistent settings");
endmodule : drive_fc_ctl
`default_nettype wire

/* File: temp_host_model.sv */
// Far-side model that supplies the temperature level and sample strobes.
`timescale 1ns/1ps
`default_nettype none
module temp_host_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] level_i,
  input  wire logic       req_i,
  output logic      [7:0] temp_o,
  output logic            sample_o
);
  // Registered so every change leaves the model just after a clock edge.
  always_ff @(posedge clk_i) begin
    temp_o   <= level_i;
    sample_o <= req_i;
  end
endmodule : temp_host_model
`default_nettype wire

/* File: drive_feature_control_states_tb.sv */
// Self-checking testbench of the feature-control interpreter.
`timescale 1ns/1ps
`default_nettype none
`include "drive_fc_cfg.svh"
module drive_feature_control_states_tb;
  import drive_fc_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, hrst = 1'b0, req = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [7:0]  lvl = 8'h2a;
  logic [31:0] wdat = 32'h0;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat_o, r;
  logic        ack, wce, idw, reo, qbusy, smp;
  logic [15:0] intv;
  logic [7:0]  temp;
  int          n_mismatch = 0;
  int          n_compared = 0;

  always #5 clk_i = ~clk_i;

  drive_fc_ctl i_drive_fc_ctl (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .hard_rst_i(hrst), .temp_i(temp), .sample_i(smp),
    .write_cache_en_o(wce), .idw85_wce_o(idw), .reorder_en_o(reo),
    .log_interval_o(intv), .queue_busy_o(qbusy));
  temp_host_model i_temp_host_model (.clk_i(clk_i), .level_i(lvl), .req_i(req),
    .temp_o(temp), .sample_o(smp));

  ////////////////////////////////////////////////////////////////////////////
  task end_of_test;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk

  // One classic cycle; read data and ack are taken at the same rising edge.
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hf;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) n_mismatch++;
    r = dat_o;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask : xfer

  task cmd(input logic [15:0] fn, ft, st, op, input logic [31:0] stat);
    xfer(1'b1, `OFS_FEAT, {16'h0, ft});
    xfer(1'b1, `OFS_STATE, {16'h0, st});
    xfer(1'b1, `OFS_OPT, {16'h0, op});
    xfer(1'b1, `OFS_FUNC, {16'h0, fn});
    xfer(1'b1, `OFS_CTRL, 32'h1);
    xfer(1'b0, `OFS_STAT, 32'h0);
    chk(r, stat);
  endtask : cmd

  task wait_idle;
    int n;
    n = 0;
    do begin
      xfer(1'b0, `OFS_STAT, 32'h0);
      n++;
    end while (r[`STAT_BUSY_BIT] !== 1'b0 && n < 100);
    chk(r, 32'h2);
  endtask : wait_idle

  task rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(r, exp);
  endtask : rd

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #400000;
    n_mismatch++;
    end_of_test;
  end

  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`OFS_IDW85, 32'h20);
    chk({reo, wce, idw}, 32'h7);
    rd(`OFS_INTV, 32'h1);
    cmd(`FN_GET, `FC_WCACHE, 16'h0, 16'h0, 32'h2);
    rd(`OFS_RES, 32'h1);
    cmd(`FN_SET, `FC_WCACHE, 16'h3, 16'h0, 32'h2);
    rd(`OFS_IDW85, 32'h0);
    cmd(`FN_SET, `FC_WCACHE, 16'h2, 16'h0, 32'h2);
    xfer(1'b1, `OFS_SETF, 32'h0);
    rd(`OFS_IDW85, 32'h20);
    chk(wce, 32'h1);
    cmd(`FN_SET, `FC_WCACHE, 16'h1, 16'h0, 32'h2);
    chk({wce, idw}, 32'h0);
    xfer(1'b1, `OFS_SETF, 32'h1);
    rd(`OFS_IDW85, 32'h20);
    cmd(`FN_SET, `FC_REORD, `RO_DIS, 16'h0, 32'h2);
    chk(reo, 32'h1);
    cmd(`FN_GET, `FC_REORD, 16'h0, 16'h0, 32'h2);
    rd(`OFS_RES, 32'h1);
    cmd(`FN_SET, 16'h0004, 16'h1, 16'h0, 32'h6);
    cmd(`FN_SET, 16'hcfff, 16'h1, 16'h0, 32'h6);
    cmd(`FN_SET, 16'hd000, 16'h1, 16'h0, 32'h6);
    cmd(`FN_SET, 16'hffff, 16'h1, 16'h0, 32'h6);
    cmd(16'h0004, `FC_WCACHE, 16'h1, 16'h0, 32'h6);
    xfer(1'b1, `OFS_SPER, 32'h5);
    xfer(1'b1, `OFS_LIM, 32'h1122_3344);
    cmd(`FN_SET, `FC_TLOG, `INTV_BAD, 16'h0, 32'h6);
    rd(`OFS_INTV, 32'h1);
    cmd(`FN_SET, `FC_TLOG, 16'h5, 16'h1, 32'h3);
    wait_idle;
    chk(intv, 32'h5);
    rd(`OFS_QIDX, 32'h0);
    xfer(1'b1, `OFS_QADR, 32'h0);
    rd(`OFS_QDAT, 32'h2a);
    xfer(1'b1, `OFS_QADR, 32'h1);
    rd(`OFS_QDAT, 32'h80);
    xfer(1'b1, `OFS_QADR, 32'h7f);
    rd(`OFS_QDAT, 32'h80);
    lvl <= 8'h33;
    repeat (4) @(posedge clk_i);
    req <= 1'b1;
    @(posedge clk_i);
    req <= 1'b0;
    repeat (3) @(posedge clk_i);
    rd(`OFS_QIDX, 32'h1);
    xfer(1'b1, `OFS_QADR, 32'h1);
    rd(`OFS_QDAT, 32'h33);
    rd(`OFS_SPER, 32'h5);
    rd(`OFS_LIM, 32'h1122_3344);
    cmd(`FN_OPT, `FC_TLOG, 16'h0, 16'h0, 32'h2);
    rd(`OFS_RES, 32'h1);
    cmd(`FN_SET, `FC_TLOG, 16'hffff, 16'h0, 32'h3);
    wait_idle;
    chk(intv, 32'hffff);
    hrst <= 1'b1;
    repeat (6) @(posedge clk_i);
    hrst <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk({intv, 15'h0, wce}, 32'h0005_0001);
    end_of_test;
  end
endmodule : drive_feature_control_states_tb
`default_nettype wire
